// [dv/ems_xmem_model.sv]
// Behavioural external data memory on the two address ports.
// Assumes the pin struct of the move block and one system clock.
`timescale 1ns/10ps
module ems_xmem_model import ems_pkg::*; #(
	parameter int RD_DLY = 1
) (
	input wire logic i_clock,
	input wire ems_pins_s i_pins,
	output logic [7:0] o_lo_in
);
	logic [7:0] mem [0:65535];
	logic [7:0] lo_latch = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] drive;
	int rd_age = 0;
	wire logic [15:0] addr = {i_pins.hi_out, lo_latch};
	// ----------------------------------------
	// Address latch, write capture, read timing
	// ----------------------------------------
	always @(posedge i_clock) begin
		if (i_pins.ale === 1'b1) begin
			lo_latch <= i_pins.lo_out;
		end
		if (i_pins.wr_n === 1'b0) begin
			mem[addr] <= i_pins.lo_out;
		end
		rd_age <= (i_pins.rd_n === 1'b0) ? rd_age + 1 : 0;
		last <= drive;
	end
	// Data is valid late in the strobe; otherwise a pattern that flips every cycle
	assign drive = (i_pins.rd_n === 1'b0 && rd_age >= RD_DLY) ? mem[addr] : ~last;
	// Wire level: the device wins where it drives
	assign o_lo_in = (i_pins.lo_oe & i_pins.lo_out) | (~i_pins.lo_oe & drive);
endmodule : ems_xmem_model

// [dv/ems_xmem_top_test.sv]
// Self-checking bench of the external data move block through its register bus.
// Assumes the memory model on the ports and a 10 MHz clock.
`timescale 1ns/10ps
`include "ems_cfg.svh"
module ems_xmem_top_test import ems_pkg::*;;
	logic i_clock;
	logic i_reset;
	logic [11:0] awaddr = 0;
	logic [11:0] araddr = 0;
	logic awvalid = 0;
	logic wvalid = 0;
	logic bready = 0;
	logic arvalid = 0;
	logic rready = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 4'hf;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp, resp;
	logic [31:0] o_rdata, rd;
	logic [7:0] lo_in, hi_in;
	logic [7:0] hi_ext = 8'h3c;
	logic [15:0] ptr;
	ems_pins_s pins;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int strobes = 0;
	int active = 0;
	assign hi_in = (pins.hi_oe & pins.hi_out) | (~pins.hi_oe & hi_ext);
	ems_xmem_top #(.ADDR_W(12)) ems_xmem_top_inst (.i_clock(i_clock), .i_reset(i_reset),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
		.o_bvalid(o_bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
		.i_rready(rready), .i_lo_in(lo_in), .i_hi_in(hi_in), .o_pins(pins));
	ems_xmem_model ems_xmem_model_inst (.i_clock(i_clock), .i_pins(pins), .o_lo_in(lo_in));
	// ----------------------------------------
	// Clock, pin monitor, watchdog
	// ----------------------------------------
	initial begin
		i_clock = 0;
		forever #50 i_clock = ~i_clock;
	end
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0) strobes <= strobes + 1;
		if (pins.hi_oe === 8'hff) active <= active + 1;
		if (cyc == 10000) begin
			bad_count++;
			complete_run();
		end
	end
	// ----------------------------------------
	// Compare, bus and move tasks
	// ----------------------------------------
	function automatic logic [11:0] ba(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction : ba
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp_val
	task automatic cmp_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		cmp_val(what, {30'h0, exp}, {30'h0, got});
	endtask : cmp_resp
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er, input string what);
		@(posedge i_clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		resp = 'x;
		for (int t = 0; t < 100; t++) begin
			@(posedge i_clock);
			if (awvalid && o_awready === 1'b1) awvalid <= 0;
			if (wvalid && o_wready === 1'b1) wvalid <= 0;
			if (o_bvalid === 1'b1) begin
				bready <= 0;
				resp = o_bresp;
				break;
			end
		end
		cmp_resp(what, er, resp);
	endtask : axw
	task automatic axr(input logic [11:0] a, input logic [1:0] er, input string what);
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		rd = 'x;
		resp = 'x;
		for (int t = 0; t < 100; t++) begin
			@(posedge i_clock);
			if (arvalid && o_arready === 1'b1) arvalid <= 0;
			if (o_rvalid === 1'b1) begin
				rready <= 0;
				rd = o_rdata;
				resp = o_rresp;
				break;
			end
		end
		cmp_resp(what, er, resp);
	endtask : axr
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		axr(a, `EMS_RESP_OKAY, what);
		cmp_val(what, exp, rd);
	endtask : rchk
	task automatic mchk(input logic [15:0] a, input logic [7:0] exp);
		cmp_val("memory byte", {24'h0, exp}, {24'h0, ems_xmem_model_inst.mem[a]});
	endtask : mchk
	task automatic do_move(input logic wr, input logic [7:0] d, input int code, input bit chg);
		int s0;
		int a0;
		s0 = strobes;
		a0 = active;
		axw(ba(`EMS_IDX_MOVE), {23'h0, wr, d}, `EMS_RESP_OKAY, "move start");
		for (int t = 0; t < 100 && pins.ale !== 1'b1; t++) @(posedge i_clock);
		if (chg) axw(ba(`EMS_IDX_CLKSTR), 32'((code + 1) % 8), `EMS_RESP_OKAY, "stretch update");
		rd = 32'h200;
		for (int t = 0; t < 100 && rd[9] !== 1'b0; t++) axr(ba(`EMS_IDX_MOVE), `EMS_RESP_OKAY, "move poll");
		// Upper port stays driven for one idle clock after the move ends
		cmp_val("move length", 32'(4 * (code + 2) + 1), 32'(active - a0));
		cmp_val("strobe width", (code == 0) ? 32'd2 : 32'(4 * code), 32'(strobes - s0));
	endtask : do_move
	task automatic tmr_rate(input logic [31:0] ck, input int per);
		logic [15:0] t0;
		int c0;
		int d;
		axw(ba(`EMS_IDX_CLKSTR), ck, `EMS_RESP_OKAY, "timer select");
		axr(ba(`EMS_IDX_TIMER), `EMS_RESP_OKAY, "timer read");
		t0 = rd[15:0];
		c0 = cyc;
		repeat (240) @(posedge i_clock);
		axr(ba(`EMS_IDX_TIMER), `EMS_RESP_OKAY, "timer read");
		d = 32'(rd[15:0] - t0) * per;
		cmp_val("timer rate", 32'h1, {31'h0, d > cyc - c0 - per && d < cyc - c0 + per});
	endtask : tmr_rate
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		i_reset = 1;
		repeat (8) @(posedge i_clock);
		i_reset <= 0;
		rchk(ba(`EMS_IDX_CLKSTR), 32'h1, "stretch reset");
		rchk(ba(`EMS_IDX_MODE), 32'h1, "mode reset");
		axr(12'h300, `EMS_RESP_SLVERR, "unmapped read");
		cmp_val("unmapped data", 32'h0, rd);
		axw(12'h239, 32'h7, `EMS_RESP_SLVERR, "unaligned write");
		rchk(ba(`EMS_IDX_CLKSTR), 32'h1, "stretch kept");
		$display("test registers done");
		for (int c = 0; c < 8; c++) begin
			ptr = 16'h1e00 + 16'(c) * 16'h0111;
			axw(ba(`EMS_IDX_CLKSTR), 32'(c), `EMS_RESP_OKAY, "stretch code");
			axw(ba(`EMS_IDX_DPTR0), {16'h0, ptr}, `EMS_RESP_OKAY, "pointer load");
			do_move(1'b1, 8'h5a ^ 8'(c), c, 1'b1);
			mchk(ptr, 8'h5a ^ 8'(c));
			do_move(1'b0, 8'h00, (c + 1) % 8, 1'b0);
			cmp_val("read byte", {24'h0, 8'h5a ^ 8'(c)}, {24'h0, rd[7:0]});
		end
		$display("test stretch done");
		axw(ba(`EMS_IDX_CLKSTR), 32'h1, `EMS_RESP_OKAY, "stretch default");
		axw(ba(`EMS_IDX_DPTR0), 32'h1200, `EMS_RESP_OKAY, "pointer zero");
		axw(ba(`EMS_IDX_DPTR1), 32'h3400, `EMS_RESP_OKAY, "pointer one");
		axw(ba(`EMS_IDX_MODE), 32'hd, `EMS_RESP_OKAY, "toggle and step");
		do_move(1'b1, 8'h11, 1, 1'b0);
		do_move(1'b1, 8'h22, 1, 1'b0);
		mchk(16'h1200, 8'h11);
		mchk(16'h3400, 8'h22);
		rchk(ba(`EMS_IDX_DPTR0), 32'h1201, "pointer zero step");
		rchk(ba(`EMS_IDX_DPTR1), 32'h3401, "pointer one step");
		rchk(ba(`EMS_IDX_MODE), 32'hd, "pointer select back");
		$display("test pointers done");
		axw(ba(`EMS_IDX_MODE), 32'h0, `EMS_RESP_OKAY, "port mode");
		axw(ba(`EMS_IDX_GPIO), 32'h00ff_5aa5, `EMS_RESP_OKAY, "port write");
		repeat (2) @(posedge i_clock);
		cmp_val("port pins", 32'h00ff_5aa5, {pins.hi_oe, pins.lo_oe, pins.hi_out, pins.lo_out});
		rchk(ba(`EMS_IDX_GPIO), 32'h00ff_3ca5, "port readback");
		axw(ba(`EMS_IDX_MOVE), 32'h100, `EMS_RESP_SLVERR, "move refused");
		cmp_val("port strobes", 32'h3, {29'h0, pins.ale, pins.rd_n, pins.wr_n});
		axw(ba(`EMS_IDX_GPIO), 32'h0, `EMS_RESP_OKAY, "port release");
		axw(ba(`EMS_IDX_MODE), 32'h1, `EMS_RESP_OKAY, "memory mode");
		$display("test ports done");
		tmr_rate(32'h1, 12);
		tmr_rate(32'h9, 4);
		$display("test timer done");
		complete_run();
	end
endmodule : ems_xmem_top_test

// [logic/ems_cfg.svh]
// Constants of the external data move block: register indices, field positions,
// reset values and clock counts.
// Assumes inclusion by the design modules and the bench of this block.
`ifndef EMS_CFG_SVH
`define EMS_CFG_SVH
// Register indices; byte address is four times the index
`define EMS_IDX_CLKSTR 10'h08e
`define EMS_IDX_MODE 10'h090
`define EMS_IDX_DPTR0 10'h091
`define EMS_IDX_DPTR1 10'h092
`define EMS_IDX_MOVE 10'h093
`define EMS_IDX_GPIO 10'h094
`define EMS_IDX_TIMER 10'h095
// Field positions
`define EMS_STR_MSB 2
`define EMS_FAST_BIT 3
`define EMS_EXT_BIT 0
`define EMS_DPS_BIT 1
`define EMS_TOG_BIT 2
`define EMS_INC_BIT 3
`define EMS_MV_WR_BIT 8
`define EMS_MV_BUSY_BIT 9
// Reset values
`define EMS_CLKSTR_RST 8'h01
`define EMS_MODE_RST 8'h01
// Clock counts
`define EMS_CLK_PER_ICYC 4
`define EMS_TMR_SLOW 12
`define EMS_TMR_FAST 4
// Bus answers
`define EMS_RESP_OKAY 2'h0
`define EMS_RESP_SLVERR 2'h2
`endif

// [logic/ems_cycle_gen.sv]
// Instruction cycle and timer increment tick generator.
// Assumes one free-running clock and a synchronous active-high reset.
`timescale 1ns/10ps
`include "ems_cfg.svh"
module ems_cycle_gen import ems_pkg::*; #(
	parameter int ICYC = `EMS_CLK_PER_ICYC,
	parameter int SLOW = `EMS_TMR_SLOW,
	parameter int FAST = `EMS_TMR_FAST
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_fast,
	output logic o_icyc_tick,
	output logic o_tmr_tick
);
	if (ICYC < 2 || ICYC > 16 || SLOW > 16 || FAST < 2 || SLOW % FAST != 0) begin : g_bad
		$error("ems_cycle_gen: unsupported divider values");
	end

	logic [3:0] iph;
	logic [3:0] tph;
	logic [3:0] next_tph;

	always_comb begin
		next_tph = (tph == 4'(SLOW - 1)) ? 4'h0 : tph + 4'h1;
	end

	// Instruction cycle of four clocks
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			iph <= 4'h0;
			o_icyc_tick <= 1'b0;
		end else begin
			iph <= (iph == 4'(ICYC - 1)) ? 4'h0 : iph + 4'h1;
			o_icyc_tick <= (iph == 4'(ICYC - 2));
		end
	end

	// Timer increment every twelve clocks, or every four when fast
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			tph <= 4'h0;
			o_tmr_tick <= 1'b0;
		end else begin
			tph <= next_tph;
			o_tmr_tick <= i_fast ? (32'(next_tph) % FAST == FAST - 1) : (next_tph == 4'(SLOW - 1));
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [4:0] gap;
	logic mixed;
	logic fast_q;
	// Mixed marks a period that saw the fast select, including the tick that opened it
	always_ff @(posedge i_clock) begin
		fast_q <= i_fast;
		if (i_reset) begin
			gap <= 5'h0;
			mixed <= 1'b0;
		end else if (o_tmr_tick) begin
			gap <= 5'h0;
			mixed <= fast_q | i_fast;
		end else begin
			gap <= gap + 5'h1;
			mixed <= mixed | i_fast;
		end
	end

	a_icyc_period: assert property (@(posedge i_clock) disable iff (i_reset)
		o_icyc_tick |=> !o_icyc_tick [*3] ##1 o_icyc_tick)
		else $error("instruction cycle tick not every four clocks");
	a_tmr_slow_rate: assert property (@(posedge i_clock) disable iff (i_reset)
		o_tmr_tick && !mixed |-> gap == 5'h0b)
		else $error("slow timer tick spacing wrong");
endmodule : ems_cycle_gen

// [logic/ems_move_seq.sv]
// Sequencer of one stretched external data move on the two address ports.
// Assumes the start pulse comes on an instruction cycle boundary while idle.
`timescale 1ns/10ps
`include "ems_cfg.svh"
module ems_move_seq import ems_pkg::*; (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic i_start,
	input wire logic [2:0] i_code,
	input wire logic i_write,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_ext_en,
	input wire logic [15:0] i_gpio_out,
	input wire logic [15:0] i_gpio_oe,
	input wire logic [7:0] i_lo_in,
	output ems_pins_s o_pins,
	output logic o_busy,
	output logic o_done,
	output logic [7:0] o_rdata
);
	localparam ems_pins_s PINS_IDLE = '{8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1};

	ems_seq_e state;
	logic [5:0] cnt;
	logic [2:0] code_q;
	logic wr_q;
	logic [15:0] addr_q;
	logic [7:0] wd_q;
	logic [5:0] strobe_len;
	logic [5:0] total_len;
	logic [5:0] hold_len;

	always_comb begin
		strobe_len = (code_q == 3'h0) ? 6'h02 : {1'b0, code_q, 2'b00};
		total_len = {4'(code_q) + 4'h2, 2'b00};
		hold_len = total_len - strobe_len - 6'h03;
	end

	// Stretch code is caught at start so later writes hit later moves only
	always_ff @(posedge i_clock) begin
		if (state == S_IDLE && i_start) begin
			code_q <= i_code;
			wr_q <= i_write;
			addr_q <= i_addr;
			wd_q <= i_wdata;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			state <= S_IDLE;
			cnt <= 6'h00;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			unique case (state)
				S_IDLE: if (i_start) begin
					state <= S_ADDR;
					cnt <= 6'h02;
					o_busy <= 1'b1;
				end
				S_ADDR: if (cnt == 6'h00) begin
					state <= S_STROBE;
					cnt <= strobe_len - 6'h01;
				end else cnt <= cnt - 6'h01;
				S_STROBE: if (cnt == 6'h00) begin
					state <= S_HOLD;
					cnt <= hold_len - 6'h01;
				end else cnt <= cnt - 6'h01;
				S_HOLD: if (cnt == 6'h00) begin
					state <= S_IDLE;
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end else cnt <= cnt - 6'h01;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) o_rdata <= 8'h00;
		else if (state == S_STROBE && cnt == 6'h00 && !wr_q) o_rdata <= i_lo_in;
	end

	// Pins: address phase with latch strobe, setup clock, strobe, hold
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_pins <= PINS_IDLE;
		end else if (state == S_IDLE && i_start) begin
			o_pins <= '{i_addr[15:8], 8'hff, i_addr[7:0], 8'hff, 1'b1, 1'b1, 1'b1};
		end else begin
			unique case (state)
				S_IDLE: o_pins <= i_ext_en ? PINS_IDLE :
					'{i_gpio_out[15:8], i_gpio_oe[15:8], i_gpio_out[7:0], i_gpio_oe[7:0], 1'b0, 1'b1, 1'b1};
				S_ADDR: if (cnt == 6'h01) begin
					o_pins.ale <= 1'b0;
					o_pins.lo_out <= wd_q;
					o_pins.lo_oe <= wr_q ? 8'hff : 8'h00;
				end else if (cnt == 6'h00) begin
					o_pins.rd_n <= wr_q;
					o_pins.wr_n <= !wr_q;
				end
				S_STROBE: if (cnt == 6'h00) begin
					o_pins.rd_n <= 1'b1;
					o_pins.wr_n <= 1'b1;
				end
				S_HOLD: if (cnt == 6'h00) o_pins.lo_oe <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic strb;
	logic [5:0] strb_run;
	logic [5:0] busy_run;
	assign strb = !o_pins.rd_n || !o_pins.wr_n;
	always_ff @(posedge i_clock) begin
		strb_run <= (i_reset || !strb) ? 6'h00 : strb_run + 6'h01;
		busy_run <= (i_reset || !o_busy) ? 6'h00 : busy_run + 6'h01;
	end

	a_strobe_width: assert property (@(posedge i_clock) disable iff (i_reset)
		$fell(strb) |-> $past(strb_run) + 6'h01 == ((code_q == 3'h0) ? 6'h02 : {1'b0, code_q, 2'b00}))
		else $error("strobe width does not match stretch code");
	a_move_length: assert property (@(posedge i_clock) disable iff (i_reset)
		$fell(o_busy) |-> $past(busy_run) + 6'h01 == {4'(code_q) + 4'h2, 2'b00})
		else $error("move length is not the stretched cycle count");
	a_latch_first: assert property (@(posedge i_clock) disable iff (i_reset)
		$rose(strb) |-> $past(o_pins.ale, 2) && !$past(o_pins.ale) && !o_pins.ale)
		else $error("latch strobe did not precede data phase");
	a_high_addr: assert property (@(posedge i_clock) disable iff (i_reset)
		o_busy |-> o_pins.hi_out == addr_q[15:8] && o_pins.hi_oe == 8'hff)
		else $error("high address byte not held on upper port");
	a_one_strobe: assert property (@(posedge i_clock) disable iff (i_reset)
		!(o_pins.rd_n == 1'b0 && o_pins.wr_n == 1'b0))
		else $error("read and write strobes both active");
endmodule : ems_move_seq

// [logic/ems_pkg.sv]
// Types shared by the external data move block.
// Assumes nothing beyond the tool's SystemVerilog support.
package ems_pkg;
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ADDR = 2'b01,
		S_STROBE = 2'b10,
		S_HOLD = 2'b11
	} ems_seq_e;

	typedef struct packed {
		logic [7:0] hi_out;
		logic [7:0] hi_oe;
		logic [7:0] lo_out;
		logic [7:0] lo_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
	} ems_pins_s;
endpackage : ems_pkg

// [logic/ems_xmem_top.sv]
// Top of the external data move block with its register slave.
// Assumes an AXI4-Lite master with one write and one read at most in flight.
`timescale 1ns/10ps
`include "ems_cfg.svh"
module ems_xmem_top import ems_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic i_clock,
	input wire logic i_reset,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [7:0] i_lo_in,
	input wire logic [7:0] i_hi_in,
	output ems_pins_s o_pins
);
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad
		$error("ems_xmem_top: address width must be 12 to 32");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction : merge

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic [7:0] clkstr;
	logic [7:0] mode;
	logic [15:0] dptr0;
	logic [15:0] dptr1;
	logic [31:0] gpio;
	logic [15:0] timer;
	logic move_pend;
	logic move_wr;
	logic [7:0] move_data;
	logic used_sel;
	logic icyc_tick;
	logic tmr_tick;
	logic busy;
	logic done;
	logic [7:0] seq_rdata;
	logic start;

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	logic aw_have;
	logic w_have;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [9:0] widx;
	logic wr_err;

	always_comb begin
		do_write = aw_have && w_have && !o_bvalid;
		widx = awaddr_q[11:2];
		unique case (widx)
			`EMS_IDX_CLKSTR, `EMS_IDX_MODE, `EMS_IDX_DPTR0, `EMS_IDX_DPTR1,
			`EMS_IDX_GPIO, `EMS_IDX_TIMER: wr_err = 1'b0;
			`EMS_IDX_MOVE: wr_err = move_pend || busy || !mode[`EMS_EXT_BIT];
			default: wr_err = 1'b1;
		endcase
		if (awaddr_q[1:0] != 2'b00 || (ADDR_W > 12 && awaddr_q >> 12 != '0)) wr_err = 1'b1;
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			aw_have <= 1'b0;
			o_awready <= 1'b0;
		end else if (i_awvalid && o_awready) begin
			aw_have <= 1'b1;
			o_awready <= 1'b0;
			awaddr_q <= i_awaddr;
		end else if (o_bvalid && i_bready) begin
			aw_have <= 1'b0;
			o_awready <= 1'b1;
		end else if (!aw_have && !o_bvalid) begin
			o_awready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			w_have <= 1'b0;
			o_wready <= 1'b0;
		end else if (i_wvalid && o_wready) begin
			w_have <= 1'b1;
			o_wready <= 1'b0;
			wdata_q <= i_wdata;
			wstrb_q <= i_wstrb;
		end else if (o_bvalid && i_bready) begin
			w_have <= 1'b0;
			o_wready <= 1'b1;
		end else if (!w_have && !o_bvalid) begin
			o_wready <= 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_bvalid <= 1'b0;
			o_bresp <= `EMS_RESP_OKAY;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			o_bresp <= wr_err ? `EMS_RESP_SLVERR : `EMS_RESP_OKAY;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic wr_ok;
	assign wr_ok = do_write && !wr_err;

	always_ff @(posedge i_clock) begin
		if (i_reset) clkstr <= `EMS_CLKSTR_RST;
		else if (wr_ok && widx == `EMS_IDX_CLKSTR && wstrb_q[0]) clkstr <= wdata_q[7:0];
	end

	// Pointer select may flip itself after a move so block copies alternate
	always_ff @(posedge i_clock) begin
		if (i_reset) mode <= `EMS_MODE_RST;
		else if (wr_ok && widx == `EMS_IDX_MODE && wstrb_q[0]) mode <= wdata_q[7:0];
		else if (done && mode[`EMS_TOG_BIT]) mode[`EMS_DPS_BIT] <= !mode[`EMS_DPS_BIT];
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			dptr0 <= 16'h0000;
			dptr1 <= 16'h0000;
		end else if (wr_ok && widx == `EMS_IDX_DPTR0) begin
			dptr0 <= 16'(merge({16'h0000, dptr0}, wdata_q, wstrb_q));
		end else if (wr_ok && widx == `EMS_IDX_DPTR1) begin
			dptr1 <= 16'(merge({16'h0000, dptr1}, wdata_q, wstrb_q));
		end else if (done && mode[`EMS_INC_BIT]) begin
			if (used_sel) dptr1 <= dptr1 + 16'h0001;
			else dptr0 <= dptr0 + 16'h0001;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) gpio <= 32'h0000_0000;
		else if (wr_ok && widx == `EMS_IDX_GPIO) gpio <= merge(gpio, wdata_q, wstrb_q);
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) timer <= 16'h0000;
		else if (tmr_tick) timer <= timer + 16'h0001;
	end

	// ----------------------------------------
	// Move request
	// ----------------------------------------
	assign start = move_pend && icyc_tick && !busy;

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			move_pend <= 1'b0;
			move_wr <= 1'b0;
			move_data <= 8'h00;
			used_sel <= 1'b0;
		end else if (wr_ok && widx == `EMS_IDX_MOVE) begin
			move_pend <= 1'b1;
			move_wr <= wdata_q[`EMS_MV_WR_BIT];
			move_data <= wdata_q[7:0];
		end else if (start) begin
			move_pend <= 1'b0;
			used_sel <= mode[`EMS_DPS_BIT];
		end
	end

	ems_cycle_gen u_cycle (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_fast(clkstr[`EMS_FAST_BIT]),
		.o_icyc_tick(icyc_tick),
		.o_tmr_tick(tmr_tick)
	);

	ems_move_seq u_seq (
		.i_clock(i_clock),
		.i_reset(i_reset),
		.i_start(start),
		.i_code(clkstr[`EMS_STR_MSB:0]),
		.i_write(move_wr),
		.i_addr(mode[`EMS_DPS_BIT] ? dptr1 : dptr0),
		.i_wdata(move_data),
		.i_ext_en(mode[`EMS_EXT_BIT]),
		.i_gpio_out(gpio[15:0]),
		.i_gpio_oe(gpio[31:16]),
		.i_lo_in(i_lo_in),
		.o_pins(o_pins),
		.o_busy(busy),
		.o_done(done),
		.o_rdata(seq_rdata)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [31:0] rd_val;
	logic rd_err;

	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		unique case (i_araddr[11:2])
			`EMS_IDX_CLKSTR: rd_val = {24'h000000, clkstr};
			`EMS_IDX_MODE: rd_val = {24'h000000, mode};
			`EMS_IDX_DPTR0: rd_val = {16'h0000, dptr0};
			`EMS_IDX_DPTR1: rd_val = {16'h0000, dptr1};
			`EMS_IDX_MOVE: rd_val = {22'h000000, busy || move_pend, move_wr, seq_rdata};
			`EMS_IDX_GPIO: rd_val = {gpio[31:16], i_hi_in, i_lo_in};
			`EMS_IDX_TIMER: rd_val = {16'h0000, timer};
			default: rd_err = 1'b1;
		endcase
		if (i_araddr[1:0] != 2'b00 || (ADDR_W > 12 && i_araddr >> 12 != '0)) rd_err = 1'b1;
	end

	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `EMS_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b1;
			o_rdata <= rd_err ? 32'h0000_0000 : rd_val;
			o_rresp <= rd_err ? `EMS_RESP_SLVERR : `EMS_RESP_OKAY;
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
			o_arready <= 1'b1;
		end else if (!o_rvalid) begin
			o_arready <= 1'b1;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_stretch_reset: assert property (@(posedge i_clock) disable iff (i_reset)
		$past(i_reset) |-> clkstr[`EMS_STR_MSB:0] == 3'h1 && mode[`EMS_EXT_BIT])
		else $error("stretch code not three cycles after reset");
	a_gpio_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
		!mode[`EMS_EXT_BIT] && !busy && !start |=> !o_pins.ale && o_pins.rd_n && o_pins.wr_n)
		else $error("memory strobes active in port mode");
	a_data_pointer_pair_toggle: assert property (@(posedge i_clock) disable iff (i_reset)
		done && mode[`EMS_TOG_BIT] && !wr_ok |=> mode[`EMS_DPS_BIT] != $past(mode[`EMS_DPS_BIT]))
		else $error("pointer select did not alternate after move");
	a_start_aligned: assert property (@(posedge i_clock) disable iff (i_reset)
		$rose(busy) |-> $past(icyc_tick) && $past(move_pend))
		else $error("move did not start on an instruction cycle");
	a_addr_phase: assert property (@(posedge i_clock) disable iff (i_reset)
		$rose(o_pins.ale) |-> {o_pins.hi_out, o_pins.lo_out} == $past(mode[`EMS_DPS_BIT] ? dptr1 : dptr0))
		else $error("move address not the selected pointer");
	// Register updates from software, finished moves and timer ticks; move refusal and read answer timing
	a_clkstr_write: assert property (@(posedge i_clock) disable iff (i_reset)
		wr_ok && widx == `EMS_IDX_CLKSTR && wstrb_q[0] |=> clkstr == $past(wdata_q[7:0]))
		else $error("stretch register write lost");
	a_port_refuse: assert property (@(posedge i_clock) disable iff (i_reset)
		do_write && widx == `EMS_IDX_MOVE && !mode[`EMS_EXT_BIT] |=> o_bvalid && o_bresp == `EMS_RESP_SLVERR)
		else $error("move accepted in port mode");
	a_ptr_step: assert property (@(posedge i_clock) disable iff (i_reset)
		done && mode[`EMS_INC_BIT] && !wr_ok |=> (used_sel ? dptr1 : dptr0) == $past(used_sel ? dptr1 : dptr0) + 16'h0001)
		else $error("used pointer did not step after move");
	a_timer_step: assert property (@(posedge i_clock) disable iff (i_reset)
		tmr_tick |=> timer == $past(timer) + 16'h0001)
		else $error("timer did not count on tick");
	a_read_answer: assert property (@(posedge i_clock) disable iff (i_reset)
		i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer not in the cycle after address");
endmodule : ems_xmem_top
